// File: pbd_dio48.sv
/*
  48-channel bidirectional digital i/o with per-bit edge interrupts and input filter.
  assumes a PCIe endpoint bridge presenting the 32-byte i/o window as an Avalon-MM slave
  (byte address, waitrequest), a 25 MHz clk and a synchronous active-high reset.
*/
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
// Contract
// RQ1: 48 channels, six groups of eight
// RQ2: software sets direction per group
// RQ3: per-bit interrupt enable and edge select
// RQ4: interrupt on chosen falling or rising edge
// RQ5: all requests merged onto one output
// RQ6: digital filter against noise and chatter
// RQ7: positive logic, one means high
// RQ8: decode 32-byte window, any aligned base
// RQ9: pin and data update within 200 ns
// RQ10: reset to inputs, interrupts off, none pending
`timescale 1ns/1ps
module pbd_dio48 (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pbd_pkg::pbd_req_type avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [pbd_pkg::CHANNELS-1:0] dio_in,
  output logic [pbd_pkg::CHANNELS-1:0] dio_out,
  output logic [pbd_pkg::CHANNELS-1:0] dio_oe,
  output logic irq
);

  localparam int CH = pbd_pkg::CHANNELS;
  localparam int LW = pbd_pkg::LO_W;
  localparam int HW = pbd_pkg::HI_W;
  localparam int GN = pbd_pkg::GROUPS;
  localparam int GW = pbd_pkg::GROUP_W;
  localparam int FW = pbd_pkg::FILT_SEL_W;
  localparam int PW = pbd_pkg::PRE_W;

  // ==========================================================================
  // state
  logic [CH-1:0] out_latch;
  logic [GN-1:0] dir;
  logic [FW-1:0] filt_sel;
  logic [CH-1:0] irq_mask;
  logic [CH-1:0] edge_rise;
  logic [CH-1:0] status;
  logic [CH-1:0] sync1;
  logic [CH-1:0] sync2;
  logic [CH-1:0] filt_now;
  logic [CH-1:0] filt_prev;
  logic [PW-1:0] pre_cnt;
  logic filt_tick;

  // ==========================================================================
  // bus decode
  // RQ8: low five address bits only
  logic [2:0] word_sel;
  logic req_any;
  logic wr_fire;
  logic rd_load;
  logic [31:0] be_mask;
  assign word_sel = avs_req.address[pbd_pkg::ADDR_W-1:2];
  assign req_any = avs_req.read | avs_req.write;
  assign wr_fire = avs_req.write & ~avs_waitrequest;
  assign rd_load = avs_req.read & avs_waitrequest;
  assign be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
                    {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};

  // ==========================================================================
  // word select
  logic sel_data_lo;
  logic sel_ctrl;
  logic sel_mask_lo;
  logic sel_mask_hi;
  logic sel_edge_lo;
  logic sel_edge_hi;
  logic sel_stat_lo;
  logic sel_stat_hi;
  assign sel_data_lo = (word_sel == pbd_pkg::REG_DATA_LO);
  assign sel_ctrl = (word_sel == pbd_pkg::REG_CTRL);
  assign sel_mask_lo = (word_sel == pbd_pkg::REG_MASK_LO);
  assign sel_mask_hi = (word_sel == pbd_pkg::REG_MASK_HI);
  assign sel_edge_lo = (word_sel == pbd_pkg::REG_EDGE_LO);
  assign sel_edge_hi = (word_sel == pbd_pkg::REG_EDGE_HI);
  assign sel_stat_lo = (word_sel == pbd_pkg::REG_STAT_LO);
  assign sel_stat_hi = (word_sel == pbd_pkg::REG_STAT_HI);

  // ==========================================================================
  // write strobes
  logic wr_data_lo;
  logic wr_ctrl;
  logic wr_mask_lo;
  logic wr_mask_hi;
  logic wr_edge_lo;
  logic wr_edge_hi;
  logic wr_stat_lo;
  logic wr_stat_hi;
  assign wr_data_lo = wr_fire & sel_data_lo;
  assign wr_ctrl = wr_fire & sel_ctrl;
  assign wr_mask_lo = wr_fire & sel_mask_lo;
  assign wr_mask_hi = wr_fire & sel_mask_hi;
  assign wr_edge_lo = wr_fire & sel_edge_lo;
  assign wr_edge_hi = wr_fire & sel_edge_hi;
  assign wr_stat_lo = wr_fire & sel_stat_lo;
  assign wr_stat_hi = wr_fire & sel_stat_hi;

  // ==========================================================================
  // next values of writable registers
  logic [31:0] wd;
  logic [31:0] ctrl_word;
  logic [31:0] next_ctrl;
  logic [LW-1:0] next_out_lo;
  logic [HW-1:0] next_out_hi;
  logic [LW-1:0] next_mask_lo;
  logic [HW-1:0] next_mask_hi;
  logic [LW-1:0] next_edge_lo;
  logic [HW-1:0] next_edge_hi;
  logic [LW-1:0] clr_lo;
  logic [HW-1:0] clr_hi;
  logic [CH-1:0] next_out;
  logic [CH-1:0] next_mask;
  logic [CH-1:0] next_edge;
  logic [CH-1:0] stat_clr;
  assign wd = avs_req.writedata & be_mask;
  assign ctrl_word = {{(32 - pbd_pkg::FILT_LSB - FW){1'b0}}, filt_sel,
                      {(pbd_pkg::FILT_LSB - pbd_pkg::DIR_LSB - GN){1'b0}}, dir,
                      out_latch[CH-1:LW]};
  assign next_ctrl = wr_ctrl ? (ctrl_word & ~be_mask) | wd : ctrl_word;
  // byte-enable merge per half
  assign next_out_lo = wr_data_lo ? (out_latch[LW-1:0] & ~be_mask) | wd : out_latch[LW-1:0];
  assign next_out_hi = next_ctrl[pbd_pkg::DATA_HI_LSB +: HW];
  assign next_mask_lo = wr_mask_lo ? (irq_mask[LW-1:0] & ~be_mask) | wd : irq_mask[LW-1:0];
  assign next_mask_hi = wr_mask_hi ? (irq_mask[CH-1:LW] & ~be_mask[HW-1:0]) | wd[HW-1:0] : irq_mask[CH-1:LW];
  assign next_edge_lo = wr_edge_lo ? (edge_rise[LW-1:0] & ~be_mask) | wd : edge_rise[LW-1:0];
  assign next_edge_hi = wr_edge_hi ? (edge_rise[CH-1:LW] & ~be_mask[HW-1:0]) | wd[HW-1:0] : edge_rise[CH-1:LW];
  assign clr_lo = wr_stat_lo ? wd : {LW{1'b0}};
  assign clr_hi = wr_stat_hi ? wd[HW-1:0] : {HW{1'b0}};
  assign next_out = {next_out_hi, next_out_lo};
  assign next_mask = {next_mask_hi, next_mask_lo};
  assign next_edge = {next_edge_hi, next_edge_lo};
  assign stat_clr = {clr_hi, clr_lo};

  // ==========================================================================
  // read words
  // RQ7: pin level read as one
  logic [31:0] rd_data_lo;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_mask_lo;
  logic [31:0] rd_mask_hi;
  logic [31:0] rd_edge_lo;
  logic [31:0] rd_edge_hi;
  logic [31:0] rd_stat_lo;
  logic [31:0] rd_stat_hi;
  assign rd_data_lo = filt_now[LW-1:0];
  assign rd_ctrl = {ctrl_word[31:HW], filt_now[CH-1:LW]};
  assign rd_mask_lo = irq_mask[LW-1:0];
  assign rd_mask_hi = {{(32 - HW){1'b0}}, irq_mask[CH-1:LW]};
  assign rd_edge_lo = edge_rise[LW-1:0];
  assign rd_edge_hi = {{(32 - HW){1'b0}}, edge_rise[CH-1:LW]};
  assign rd_stat_lo = status[LW-1:0];
  assign rd_stat_hi = {{(32 - HW){1'b0}}, status[CH-1:LW]};

  // ==========================================================================
  // read mux
  logic [31:0] rd_word;
  assign rd_word = sel_data_lo ? rd_data_lo :
                   sel_ctrl ? rd_ctrl :
                   sel_mask_lo ? rd_mask_lo :
                   sel_mask_hi ? rd_mask_hi :
                   sel_edge_lo ? rd_edge_lo :
                   sel_edge_hi ? rd_edge_hi :
                   sel_stat_lo ? rd_stat_lo :
                   rd_stat_hi;

  // ==========================================================================
  // bus handshake, one wait cycle
  // RQ9: answer well inside 200 ns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req_any & avs_waitrequest);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= pbd_pkg::RST_WORD;
    end else if (rd_load) begin
      avs_readdata <= rd_word;
    end
  end

  // ==========================================================================
  // configuration registers
  // RQ10: inputs, disabled, nothing pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_latch <= pbd_pkg::RST_CH;
      dir <= pbd_pkg::RST_DIR;
      filt_sel <= pbd_pkg::RST_FILT;
      irq_mask <= pbd_pkg::RST_CH;
      edge_rise <= pbd_pkg::RST_CH;
    end else begin
      out_latch <= next_out;
      dir <= next_ctrl[pbd_pkg::DIR_LSB +: GN];
      filt_sel <= next_ctrl[pbd_pkg::FILT_LSB +: FW];
      irq_mask <= next_mask;
      edge_rise <= next_edge;
    end
  end

  // ==========================================================================
  // pin drivers
  // RQ2: group direction to enables
  logic [CH-1:0] next_oe;
  genvar g;
  generate
    for (g = 0; g < GN; g++) begin : gen_grp
      // RQ1: eight channels per group
      assign next_oe[g*GW +: GW] = {GW{dir[g]}};
    end
  endgenerate

  // RQ9: dio_out follows write next edge, dio_oe one edge later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dio_out <= pbd_pkg::RST_CH;
      dio_oe <= pbd_pkg::RST_CH;
    end else begin
      dio_out <= next_out;
      dio_oe <= next_oe;
    end
  end

  // ==========================================================================
  // input synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= pbd_pkg::RST_CH;
      sync2 <= pbd_pkg::RST_CH;
      filt_prev <= pbd_pkg::RST_CH;
    end else begin
      sync1 <= dio_in;
      sync2 <= sync1;
      filt_prev <= filt_now;
    end
  end

  // ==========================================================================
  // filter prescaler, period set by filt_sel
  logic [PW-1:0] pre_top;
  logic filt_bypass;
  assign pre_top = PW'(pbd_pkg::FILT_UNIT_CYC * filt_sel - 1);
  assign filt_bypass = (filt_sel == pbd_pkg::RST_FILT);

  always_ff @(posedge clk) begin
    if (sys_rst || filt_bypass) begin
      pre_cnt <= '0;
      filt_tick <= 1'b0;
    end else if (pre_cnt >= pre_top) begin
      pre_cnt <= '0;
      filt_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
      filt_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // per-channel filter and interrupt flag
  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : gen_ch
      // RQ6: filter each input
      pbd_debounce u_flt (
        .clk(clk),
        .sys_rst(sys_rst),
        .tick(filt_tick),
        .bypass(filt_bypass),
        .raw(sync2[c]),
        .filt(filt_now[c])
      );
      // RQ3: flag per channel
      pbd_irq_bit u_irq (
        .clk(clk),
        .sys_rst(sys_rst),
        .cur(filt_now[c]),
        .prev(filt_prev[c]),
        .rise_sel(edge_rise[c]),
        .clr(stat_clr[c]),
        .flag(status[c])
      );
    end
  endgenerate

  // ==========================================================================
  // merged interrupt
  // RQ5: one level output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_mask);
    end
  end

endmodule

// File: pbd_pkg.sv
/*
  shared constants and carriers for the 48-channel bidirectional digital i/o block.
  assumes a single 25 MHz clock and an Avalon-MM slave port decoding a 32-byte window.
*/
package pbd_pkg;

  // ==========================================================================
  // geometry
  localparam int GROUPS = 6;
  localparam int GROUP_W = 8;
  localparam int CHANNELS = GROUPS * GROUP_W;
  localparam int LO_W = 32;
  localparam int HI_W = CHANNELS - LO_W;

  // ==========================================================================
  // timing
  localparam int CLK_KHZ = 25_000;
  localparam int RESP_NS = 200;
  localparam int RESP_CYC = RESP_NS * CLK_KHZ / 1_000_000;
  localparam int FILT_UNIT_NS = 1000;
  localparam int FILT_UNIT_CYC = FILT_UNIT_NS * CLK_KHZ / 1_000_000;
  localparam int FILT_STABLE = 4;
  localparam int FILT_SEL_W = 4;
  localparam int PRE_W = 9;
  localparam int STB_W = 3;

  // ==========================================================================
  // register map, word indices inside the 32-byte window
  localparam int ADDR_W = 5;
  localparam logic [2:0] REG_DATA_LO = 3'h0;
  localparam logic [2:0] REG_CTRL = 3'h1;
  localparam logic [2:0] REG_MASK_LO = 3'h2;
  localparam logic [2:0] REG_MASK_HI = 3'h3;
  localparam logic [2:0] REG_EDGE_LO = 3'h4;
  localparam logic [2:0] REG_EDGE_HI = 3'h5;
  localparam logic [2:0] REG_STAT_LO = 3'h6;
  localparam logic [2:0] REG_STAT_HI = 3'h7;
  localparam int DATA_HI_LSB = 0;
  localparam int DIR_LSB = 16;
  localparam int FILT_LSB = 24;

  // ==========================================================================
  // reset values
  localparam logic [CHANNELS-1:0] RST_CH = 48'h0000_0000_0000;
  localparam logic [GROUPS-1:0] RST_DIR = 6'h00;
  localparam logic [FILT_SEL_W-1:0] RST_FILT = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } pbd_req_type;

endpackage

// File: pbd_debounce.sv
/*
  one-channel input filter: bypass or accept a level once stable for several ticks.
  assumes raw is already synchronised to clk and tick is a one-cycle enable.
*/
`timescale 1ns/1ps
module pbd_debounce (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick,
  input wire logic bypass,
  input wire logic raw,
  output logic filt
);

  logic [pbd_pkg::STB_W-1:0] cnt;
  logic held;

  // ==========================================================================
  // stability counter
  // RQ6: reject short pulses
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      filt <= 1'b0;
      held <= 1'b0;
      cnt <= '0;
    end else if (bypass) begin
      filt <= raw;
      held <= raw;
      cnt <= '0;
    end else if (raw != held) begin
      held <= raw;
      cnt <= '0;
    end else if (tick) begin
      if (cnt == pbd_pkg::STB_W'(pbd_pkg::FILT_STABLE - 1)) begin
        filt <= held;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

endmodule

// File: pbd_irq_bit.sv
/*
  one-channel edge detector with a sticky, write-one-to-clear flag.
  assumes cur and prev are successive filtered samples on clk.
*/
`timescale 1ns/1ps
module pbd_irq_bit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cur,
  input wire logic prev,
  input wire logic rise_sel,
  input wire logic clr,
  output logic flag
);

  logic hit;

  // ==========================================================================
  // edge select
  // RQ4: chosen edge only
  assign hit = rise_sel ? (cur & ~prev) : (~cur & prev);

  // ==========================================================================
  // sticky flag, set beats clear
  // RQ3: per-bit event flag
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

endmodule

// File: pbd_dio48_assertions.sv
/*
  port checker for the 48-channel digital i/o block.
  assumes it is bound to pbd_dio48 and sees only its ports.
*/
`timescale 1ns/1ps
module pbd_dio48_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire pbd_pkg::pbd_req_type avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [pbd_pkg::CHANNELS-1:0] dio_in,
  input wire logic [pbd_pkg::CHANNELS-1:0] dio_out,
  input wire logic [pbd_pkg::CHANNELS-1:0] dio_oe,
  input wire logic irq
);
  // ==========================================================================
  // helpers
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic grp_ok;
  always_comb begin
    grp_ok = 1'b1;
    for (int g = 0; g < pbd_pkg::GROUPS; g++) begin
      if (dio_oe[g*8 +: 8] != {8{dio_oe[g*8]}}) grp_ok = 1'b0;
    end
  end
  sequence s_take;
    (avs_req.read || avs_req.write) && avs_waitrequest;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // ==========================================================================
  // checks
  AST_ONE_WAIT: assert property (s_take |=> s_ack)
    else $error("no answer after one wait cycle");
  AST_SHORT_ACK: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("acknowledge longer than one cycle");
  AST_RD_LOAD: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && $past(avs_req.read))
    else $error("read data moved outside a read");
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> dio_oe == '0 && dio_out == '0 && !irq)
    else $error("outputs not idle after reset");
  AST_GROUP_DIR: assert property (grp_ok)
    else $error("group enables differ");
  AST_OE_BY_WRITE: assert property (!$stable(dio_oe) |-> $past(avs_req.write && !avs_waitrequest, 2))
    else $error("direction moved without write");
  AST_OUT_BY_WRITE: assert property (!$stable(dio_out) |-> $past(avs_req.write && !avs_waitrequest))
    else $error("output moved without write");
  AST_IRQ_DROP: assert property ($fell(irq) |-> $past(avs_req.write && !avs_waitrequest, 2))
    else $error("interrupt dropped without write");
endmodule
bind pbd_dio48 pbd_dio48_assertions chk (.clk, .sys_rst, .avs_req, .avs_readdata, .avs_waitrequest,
  .dio_in, .dio_out, .dio_oe, .irq);

// File: pbd_host.sv
/*
  host-side model: avalon-mm master reaching the 32-byte window.
  assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module pbd_host (
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output pbd_pkg::pbd_req_type avs_req
);
  initial avs_req = '0;
  task automatic acc(input logic w, input logic [2:0] r, input logic [31:0] d, output logic [31:0] q,
                     output bit ok);
    @(posedge clk);
    avs_req <= '{read: !w, write: w, address: {r, 2'h0}, byteenable: 4'hF, writedata: d};
    ok = 1'b0;
    for (int i = 0; i < 16 && !ok; i++) begin
      @(posedge clk);
      if (!avs_waitrequest) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    avs_req <= '0;
  endtask
endmodule

// File: test_pcie_bidir_digital_io_48.sv
/*
  self-checking bench for the 48-channel digital i/o block.
  assumes pbd_host as bus master and bench-driven external pins.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module test_pcie_bidir_digital_io_48;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [47:0] ext = '0;
  wire [47:0] pin;
  pbd_pkg::pbd_req_type avs_req;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, irq;
  logic [47:0] dio_out, dio_oe, m_out, m_oe, m_mask, m_edge, m_stat, a, b;
  logic [5:0] m_dir;
  int fails = 0;
  int cmp_count = 0;
  bit ok;
  function automatic logic [47:0] rnd48();
    return 48'({$urandom, $urandom});
  endfunction
  assign pin = (dio_oe & dio_out) | (~dio_oe & ext);
  initial forever #20 clk = ~clk;
  pbd_dio48 dut (.clk, .sys_rst, .avs_req, .avs_readdata, .avs_waitrequest, .dio_in(pin), .dio_out, .dio_oe, .irq);
  pbd_host host (.clk, .avs_waitrequest, .avs_readdata, .avs_req);
  task complete_run;
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task acc(input logic w, input logic [2:0] r, input logic [31:0] d);
    host.acc(w, r, d, q, ok);
    if (!ok) begin
      fails++;
      complete_run;
    end
  endtask
  task rchk(input logic [2:0] r, input logic [31:0] e);
    acc(1'b0, r, 32'h0);
    `CHK(q, e)
  endtask
  task setpins(input logic [47:0] v);
    @(posedge clk);
    ext <= v;
    repeat (3) @(posedge clk);
  endtask
  task wr48(input logic [2:0] r, input logic [47:0] v);
    acc(1'b1, r, v[31:0]);
    acc(1'b1, r + 3'h1, {16'h0, v[47:32]});
  endtask
  initial begin
    void'($urandom(32'hD5BB8077));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK({dio_oe, dio_out, irq}, 97'h0)
    rchk(pbd_pkg::REG_MASK_LO, 32'h0);
    rchk(pbd_pkg::REG_CTRL, 32'h0);
    m_dir = 6'($urandom);
    m_out = rnd48();
    for (int g = 0; g < 6; g++) m_oe[g*8 +: 8] = {8{m_dir[g]}};
    acc(1'b1, pbd_pkg::REG_DATA_LO, m_out[31:0]);
    acc(1'b1, pbd_pkg::REG_CTRL, {10'h0, m_dir, m_out[47:32]});
    repeat (2) @(posedge clk);
    `CHK(dio_oe, m_oe)
    `CHK(dio_out & m_oe, m_out & m_oe)
    setpins(rnd48());
    rchk(pbd_pkg::REG_DATA_LO, 32'((m_oe & m_out) | (~m_oe & ext)));
    acc(1'b1, pbd_pkg::REG_CTRL, 32'h0);
    for (int k = 0; k < 3; k++) begin
      a = rnd48();
      b = rnd48();
      m_edge = rnd48();
      m_mask = (k == 2) ? 48'h0 : rnd48();
      wr48(pbd_pkg::REG_EDGE_LO, m_edge);
      wr48(pbd_pkg::REG_MASK_LO, m_mask);
      setpins(a);
      repeat (3) @(posedge clk);
      wr48(pbd_pkg::REG_STAT_LO, '1);
      setpins(b);
      repeat (3) @(posedge clk);
      m_stat = (m_edge & ~a & b) | (~m_edge & a & ~b);
      rchk(pbd_pkg::REG_STAT_LO, m_stat[31:0]);
      rchk(pbd_pkg::REG_STAT_HI, {16'h0, m_stat[47:32]});
      `CHK(irq, |(m_stat & m_mask))
      wr48(pbd_pkg::REG_STAT_LO, m_stat);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      rchk(pbd_pkg::REG_STAT_LO, 32'h0);
    end
    acc(1'b1, pbd_pkg::REG_CTRL, 32'h0100_0000);
    a = ext;
    setpins(~a);
    setpins(a);
    repeat (200) @(posedge clk);
    rchk(pbd_pkg::REG_DATA_LO, a[31:0]);
    rchk(pbd_pkg::REG_STAT_HI, 32'h0);
    setpins(~a);
    repeat (200) @(posedge clk);
    rchk(pbd_pkg::REG_DATA_LO, ~a[31:0]);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    `CHK({dio_oe, irq}, 49'h0)
    rchk(pbd_pkg::REG_MASK_HI, 32'h0);
    rchk(pbd_pkg::REG_CTRL, {16'h0, ext[47:32]});
    complete_run;
  end
endmodule
